// [fim_defines.svh]
`ifndef FIM_DEFINES_SVH
`define FIM_DEFINES_SVH
// register offsets on the control port
`define FIM_CHAN_MASK_ADDR 8'h2A
`define FIM_TYPE_MASK_ADDR 8'h2B
`define FIM_SYS_LATCH_ADDR 8'h2C
`define FIM_SUM_LATCH_ADDR 8'h2D
// reset values
`define FIM_CHAN_MASK_RST 8'h03
`define FIM_TYPE_MASK_RST 8'h00
`define FIM_LATCH_RST 8'h00
// latch field positions
`define FIM_SYS_ASI_CLK_BIT 7
`define FIM_SYS_PLL_LOCK_BIT 6
`define FIM_SYS_OVER_TEMP_BIT 5
`define FIM_SYS_OVER_CUR_BIT 4
`define FIM_SUM_CH1_BIT 7
`define FIM_SUM_BAT_BIT 1
// fault type positions inside one channel's byte
`define FIM_FT_OPEN_BIT 7
`define FIM_FT_PAIR_BIT 6
`define FIM_FT_P_GND_BIT 5
`define FIM_FT_M_GND_BIT 4
`define FIM_FT_P_BIAS_BIT 3
`define FIM_FT_M_BIAS_BIT 2
`define FIM_FT_P_BAT_BIT 1
`define FIM_FT_M_BAT_BIT 0
// timing
`define FIM_CLK_MHZ 200
`define FIM_US_CYCLES (`FIM_CLK_MHZ)
`define FIM_PULSE_US 2000
`define FIM_PERIOD_US 4000
`endif

// [fim_latch.sv]
//
// Behaviour
// - channel mask bits 7..4 mask input DC faults of channels 1..4; 1 masks.
// - fault type mask bit 7 masks open input, bit 6 shorted pair.
// - fault type mask bits 5/4 mask positive/negative input short to ground.
// - fault type mask bits 3/2 mask positive/negative short to bias supply.
// - fault type mask bits 1/0 mask positive/negative short to battery.
//   the code masks a channel summary bit only when all type mask bits are set, and the battery bit only when bits 1 and 0 both are.
// - system latch bit 7 records serial port clock error, self-clearing.
// - system latch bit 6 records PLL lock, self-clearing.
// - system latch bit 5 records boost or bias over-temperature.
// - system latch bit 4 records boost or bias over-current.
// - both latch registers read-only, reset zero, reserved bits read zero.
// - summary latch has status bits 7,6,5,4,1; 3,2,0 reserved.
// - summary bits 7..4 flag faults per channel; bit 1 battery short.
// - clear rule 0 clears on read if live low; 1 clears, rearms on rise.
// - readback filter 1 shows only unmasked latched events.
// - pin mode 0 level, mode 2 2ms every 4ms, mode 3 one 2ms pulse.
//
`include "fim_defines.svh"
module fim_latch #(
	parameter int unsigned PULSE_US = `FIM_PULSE_US,
	parameter int unsigned PERIOD_US = `FIM_PERIOD_US
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// control port register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// configuration held elsewhere in the device
	input wire logic latch_clear_rule,
	input wire logic latch_readback_filter,
	input wire logic [1:0] irq_event_mode,
	input wire logic irq_active_high,
	input wire logic [3:0] sys_event_mask,
	// live fault sources
	input wire logic asi_clk_err_live,
	input wire logic pll_lock_live,
	input wire logic over_temp_live,
	input wire logic over_cur_live,
	input wire logic [31:0] chan_fault_live,
	input wire logic vbat_below_bias,
	// interrupt pin
	output logic irq_pin
);
	fim_pkg::fim_state_t st_reg;
	fim_pkg::fim_state_t st_next;
	logic [7:0] sys_live;
	logic [7:0] sum_live;
	logic [7:0] sys_unmask;
	logic [7:0] sum_unmask;
	logic [3:0] chan_hit;
	logic [7:0] bat_bits;

	// ----------------------------------------
	// live status words
	// ----------------------------------------
	// a channel counts only through fault types it actually has
	always_comb
	begin
		sys_live = 8'h00;
		sys_live[`FIM_SYS_ASI_CLK_BIT] = asi_clk_err_live;
		sys_live[`FIM_SYS_PLL_LOCK_BIT] = pll_lock_live;
		sys_live[`FIM_SYS_OVER_TEMP_BIT] = over_temp_live;
		sys_live[`FIM_SYS_OVER_CUR_BIT] = over_cur_live;
		bat_bits = 8'h00;
		for (int i = 0; i < 4; i++)
		begin
			chan_hit[i] = |chan_fault_live[31 - 8 * i -: 8];
			bat_bits[2 * i] = chan_fault_live[31 - 8 * i - 7 + `FIM_FT_M_BAT_BIT];
			bat_bits[2 * i + 1] = chan_fault_live[31 - 8 * i - 7 + `FIM_FT_P_BAT_BIT];
		end
		sum_live = 8'h00;
		for (int i = 0; i < 4; i++)
		begin
			sum_live[`FIM_SUM_CH1_BIT - i] = chan_hit[i];
		end
		sum_live[`FIM_SUM_BAT_BIT] = vbat_below_bias & (|bat_bits);
	end

	// ----------------------------------------
	// mask gating per latch bit
	// ----------------------------------------
	// a channel summary bit is unmasked if its channel is and any fault type is unmasked
	always_comb
	begin
		sys_unmask = {~sys_event_mask, 4'h0};
		sum_unmask = 8'h00;
		for (int i = 0; i < 4; i++)
		begin
			sum_unmask[`FIM_SUM_CH1_BIT - i] = ~st_reg.chan_mask[7 - i]
				& (|(chan_fault_live[31 - 8 * i -: 8] & ~st_reg.type_mask)
				| ~(&st_reg.type_mask));
		end
		sum_unmask[`FIM_SUM_BAT_BIT] = ~(&st_reg.type_mask[`FIM_FT_P_BAT_BIT:`FIM_FT_M_BAT_BIT]);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic [7:0] sys_set;
		logic [7:0] sum_set;
		logic [7:0] sys_clr;
		logic [7:0] sum_clr;
		logic pend;
		logic new_evt;
		logic us_tick;
		logic [11:0] ms_inc;
		sys_set = 8'h00;
		sum_set = 8'h00;
		sys_clr = 8'h00;
		sum_clr = 8'h00;
		pend = 1'b0;
		new_evt = 1'b0;
		us_tick = 1'b0;
		ms_inc = 12'h000;
		st_next = st_reg;
		// rule 1 arms only on a rising live edge, so a stuck fault reads once
		if (latch_clear_rule)
		begin
			sys_set = sys_live & ~st_reg.sys_live_prev;
			sum_set = sum_live & ~st_reg.sum_live_prev;
		end
		else
		begin
			sys_set = sys_live;
			sum_set = sum_live;
		end
		// register writes; latch registers are read-only
		if (reg_wr)
		begin
			if (reg_addr == `FIM_CHAN_MASK_ADDR)
			begin
				st_next.chan_mask = reg_wdata;
			end
			if (reg_addr == `FIM_TYPE_MASK_ADDR)
			begin
				st_next.type_mask = reg_wdata;
			end
		end
		// register reads: data and clear-on-read
		st_next.rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`FIM_CHAN_MASK_ADDR: st_next.rdata = st_reg.chan_mask;
				`FIM_TYPE_MASK_ADDR: st_next.rdata = st_reg.type_mask;
				`FIM_SYS_LATCH_ADDR:
				begin
					st_next.rdata = latch_readback_filter ?
						st_reg.sys_latch & sys_unmask : st_reg.sys_latch;
					sys_clr = latch_clear_rule ? 8'hFF : ~sys_live;
				end
				`FIM_SUM_LATCH_ADDR:
				begin
					st_next.rdata = latch_readback_filter ?
						st_reg.sum_latch & sum_unmask : st_reg.sum_latch;
					sum_clr = latch_clear_rule ? 8'hFF : ~sum_live;
				end
				default: st_next.rdata = 8'h00;
			endcase
		end
		// a set in the clearing cycle wins so no event is lost
		st_next.sys_latch = ((st_reg.sys_latch & ~sys_clr) | sys_set) & 8'hF0;
		st_next.sum_latch = ((st_reg.sum_latch & ~sum_clr) | sum_set) & 8'hF2;
		st_next.sys_live_prev = sys_live;
		st_next.sum_live_prev = sum_live;
		// pending on any unmasked latched bit
		pend = |(st_reg.sys_latch & sys_unmask) | |(st_reg.sum_latch & sum_unmask);
		new_evt = pend & ~st_reg.pend_prev;
		st_next.pend_prev = pend;
		// microsecond divider feeding the millisecond-scale counter
		if (st_reg.us_cnt == 8'(`FIM_US_CYCLES - 1))
		begin
			st_next.us_cnt = 8'h00;
			us_tick = 1'b1;
		end
		else
		begin
			st_next.us_cnt = st_reg.us_cnt + 8'h01;
		end
		ms_inc = us_tick ? st_reg.ms_cnt + 12'h001 : st_reg.ms_cnt;
		// pin sequencer
		case (st_reg.irq_st)
			fim_pkg::FIM_ST_IDLE:
			begin
				st_next.ms_cnt = 12'h000;
				if (irq_event_mode == fim_pkg::FIM_EV_REPEAT && pend)
				begin
					st_next.irq_st = fim_pkg::FIM_ST_ON;
				end
				else if (irq_event_mode == fim_pkg::FIM_EV_ONCE && new_evt)
				begin
					st_next.irq_st = fim_pkg::FIM_ST_ON;
				end
			end
			fim_pkg::FIM_ST_ON:
			begin
				st_next.ms_cnt = ms_inc;
				if (us_tick && ms_inc == 12'(PULSE_US))
				begin
					st_next.irq_st = irq_event_mode == fim_pkg::FIM_EV_REPEAT ?
						fim_pkg::FIM_ST_OFF : fim_pkg::FIM_ST_IDLE;
				end
			end
			fim_pkg::FIM_ST_OFF:
			begin
				st_next.ms_cnt = ms_inc;
				if (us_tick && ms_inc == 12'(PERIOD_US))
				begin
					st_next.irq_st = fim_pkg::FIM_ST_IDLE;
				end
			end
			default: st_next.irq_st = fim_pkg::FIM_ST_IDLE;
		endcase
		// switching to level or unused mode abandons any running pulse train
		if (irq_event_mode != fim_pkg::FIM_EV_REPEAT && irq_event_mode != fim_pkg::FIM_EV_ONCE)
		begin
			st_next.irq_st = fim_pkg::FIM_ST_IDLE;
		end
		// unused mode 1 behaves as level mode
		if (irq_event_mode == fim_pkg::FIM_EV_REPEAT || irq_event_mode == fim_pkg::FIM_EV_ONCE)
		begin
			st_next.irq_pin = (st_next.irq_st == fim_pkg::FIM_ST_ON) ~^ irq_active_high;
		end
		else
		begin
			st_next.irq_pin = pend ~^ irq_active_high;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			st_reg <= '0;
			st_reg.chan_mask <= `FIM_CHAN_MASK_RST;
			st_reg.type_mask <= `FIM_TYPE_MASK_RST;
			st_reg.sys_latch <= `FIM_LATCH_RST;
			st_reg.sum_latch <= `FIM_LATCH_RST;
			st_reg.irq_st <= fim_pkg::FIM_ST_IDLE;
			st_reg.irq_pin <= 1'b1; // idle for active-low default
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign irq_pin = st_reg.irq_pin;
endmodule

// [fim_latch_checker.sv]
module fim_latch_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// configuration and sources
	input wire logic latch_clear_rule,
	input wire logic latch_readback_filter,
	input wire logic [1:0] irq_event_mode,
	input wire logic irq_active_high,
	input wire logic [3:0] sys_event_mask,
	input wire logic asi_clk_err_live,
	input wire logic [31:0] chan_fault_live,
	input wire logic vbat_below_bias,
	// interrupt pin
	input wire logic irq_pin
);
	// ----------------
	// port properties
	// ----------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// read decodes and the ch4 battery short
	wire rd_sys = reg_rd && reg_addr == 8'h2C;
	wire rd_sum = reg_rd && reg_addr == 8'h2D;
	wire plain = !latch_clear_rule && !latch_readback_filter;
	wire bat4 = vbat_below_bias && chan_fault_live[0];
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_sys_resvd: assert property (rd_sys |=> reg_rdata[3:0] == 4'h0)
		else $error("system latch reserved bits");
	a_sum_resvd: assert property (rd_sum |=> {reg_rdata[3:2], reg_rdata[0]} == 3'h0)
		else $error("summary reserved bits");
	a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h2A || reg_addr > 8'h2D)
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_asi_held: assert property (rd_sys && plain && asi_clk_err_live
		&& $past(asi_clk_err_live) && !$past(srst) |=> reg_rdata[7]) else $error("clock error lost");
	a_rule1_clear: assert property ((rd_sys && latch_clear_rule && !asi_clk_err_live)
		##1 !asi_clk_err_live ##1 (rd_sys && !asi_clk_err_live) |=> !reg_rdata[7])
		else $error("latch not cleared");
	a_irq_level: assert property (irq_event_mode == 2'b00 && irq_active_high
		&& !sys_event_mask[3] && !latch_clear_rule && asi_clk_err_live |-> ##[1:2] irq_pin)
		else $error("pin not asserted");
	a_sum_bat: assert property (rd_sum && plain && bat4 && $past(bat4) && !$past(srst)
		|=> reg_rdata[1] && reg_rdata[4]) else $error("battery summary lost");
endmodule
bind fim_latch fim_latch_checker fim_latch_checker_i (.sys_clk, .srst, .reg_addr, .reg_rd,
	.reg_rdata, .latch_clear_rule, .latch_readback_filter, .irq_event_mode, .irq_active_high,
	.sys_event_mask, .asi_clk_err_live, .chan_fault_live, .vbat_below_bias, .irq_pin);

// [fim_latch_tb.sv]
module fim_latch_tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
		$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
	// ---------------
	// bench signals
	// ---------------
	logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq_pin;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, r;
	logic latch_clear_rule = 1'b0, latch_readback_filter = 1'b0, irq_active_high = 1'b1;
	logic [1:0] irq_event_mode = 2'h0;
	logic [3:0] sys_event_mask = 4'hF, sys_live = 4'h0;
	logic [31:0] chan_fault_live = 32'h0;
	logic vbat_below_bias = 1'b0;
	int n_errors = 0, compares = 0, seed = 32'hD091, hi;
	// short pin timing: 3 us on in 6 us
	fim_latch #(.PULSE_US(3), .PERIOD_US(6)) fim_latch_i (.sys_clk, .srst, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .latch_clear_rule, .latch_readback_filter,
		.irq_event_mode, .irq_active_high, .sys_event_mask, .asi_clk_err_live(sys_live[3]),
		.pll_lock_live(sys_live[2]), .over_temp_live(sys_live[1]), .over_cur_live(sys_live[0]),
		.chan_fault_live, .vbat_below_bias, .irq_pin);
	initial
	begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// model of the system latch view, filter hides masked bits
	function automatic logic [7:0] sys_view(input logic [3:0] lat);
		return {latch_readback_filter ? lat & ~sys_event_mask : lat, 4'h0};
	endfunction
	// register cycles, driven on the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		`CHK(reg_rdata, e)
	endtask
	// one-cycle source event
	task automatic pulse(input logic [3:0] s, input logic [31:0] c);
		@(negedge sys_clk);
		sys_live = s;
		chan_fault_live = c;
		@(negedge sys_clk);
		sys_live = 4'h0;
		chan_fault_live = 32'h0;
	endtask
	task automatic close_out();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// watchdog, run needs about 7.6k cycles
	initial
	begin
		#200000;
		n_errors++;
		close_out();
	end
	initial
	begin
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		srst = 1'b0;
		rd(8'h2A, 8'h03);
		rd(8'h2B, 8'h00);
		rd(8'h2C, 8'h00);
		rd(8'h2D, 8'h00);
		rd(8'h10, 8'h00);
		// reserved mask bits are written with their reset value; latch writes ignored
		for (int i = 0; i < 3; i++)
		begin
			r = 8'($random(seed));
			wr(8'h2A, {r[7:4], 4'h3});
			wr(8'h2B, ~r);
			wr(8'h2C, r);
			rd(8'h2A, {r[7:4], 4'h3});
			rd(8'h2B, ~r);
			rd(8'h2C, 8'h00);
		end
		wr(8'h2B, 8'h00);
		$display("registers done");
		// masked events still latch; a read with the source low clears
		for (int i = 0; i < 4; i++)
		begin
			pulse(4'h8 >> i, 32'h0);
			rd(8'h2C, sys_view(4'h8 >> i));
			rd(8'h2C, 8'h00);
		end
		sys_live = 4'h8;
		rd(8'h2C, 8'h80);
		rd(8'h2C, 8'h80);
		latch_clear_rule = 1'b1;
		rd(8'h2C, 8'h80);
		rd(8'h2C, 8'h00);
		sys_live = 4'h0;
		pulse(4'h8, 32'h0);
		rd(8'h2C, 8'h80);
		rd(8'h2C, 8'h00);
		rd(8'h2C, 8'h00);
		latch_clear_rule = 1'b0;
		sys_event_mask = 4'h8;
		latch_readback_filter = 1'b1;
		pulse(4'hC, 32'h0);
		rd(8'h2C, sys_view(4'hC));
		latch_readback_filter = 1'b0;
		rd(8'h2C, 8'h00);
		$display("system latch done");
		for (int c = 0; c < 4; c++)
		begin
			pulse(4'h0, 32'h80 << (8 * (3 - c)));
			rd(8'h2D, 8'h80 >> c);
		end
		vbat_below_bias = 1'b1;
		chan_fault_live = 32'h1;
		rd(8'h2D, 8'h12);
		chan_fault_live = 32'h0;
		rd(8'h2D, 8'h12);
		rd(8'h2D, 8'h00);
		// filter shows the summary bit of an unmasked channel
		wr(8'h2A, 8'h73);
		latch_readback_filter = 1'b1;
		pulse(4'h0, 32'h8800_0000);
		rd(8'h2D, 8'h80);
		latch_readback_filter = 1'b0;
		rd(8'h2D, 8'h00);
		$display("summary done");
		// level pin both polarities; masked channel stays quiet
		wr(8'h2A, 8'hF3);
		sys_event_mask = 4'h7;
		for (int m = 0; m < 2; m++)
		begin
			irq_active_high = m[0];
			pulse(4'hC, 32'h8000_0000);
			repeat (3) @(negedge sys_clk);
			`CHK(irq_pin, m[0])
			rd(8'h2C, 8'hC0);
			repeat (3) @(negedge sys_clk);
			`CHK(irq_pin, !m[0])
		end
		// unused mode 1 must behave as level mode
		irq_event_mode = 2'h1;
		pulse(4'h8, 32'h0);
		repeat (3) @(negedge sys_clk);
		`CHK(irq_pin, 1'b1)
		rd(8'h2C, 8'h80);
		repeat (3) @(negedge sys_clk);
		`CHK(irq_pin, 1'b0)
		// repeat and one-shot modes, 200 cycles a microsecond
		for (int m = 2; m < 4; m++)
		begin
			irq_event_mode = m[1:0];
			pulse(4'h8, 32'h0);
			hi = 0;
			repeat (3000)
			begin
				@(negedge sys_clk);
				hi += irq_pin;
			end
			`CHK(hi > (m == 2 ? 1500 : 340) && hi <= (m == 2 ? 1800 : 600), 1'b1)
			rd(8'h2C, 8'h80);
			repeat (700) @(negedge sys_clk);
		end
		$display("interrupt pin done");
		close_out();
	end
endmodule

// [fim_pkg.sv]
package fim_pkg;
	// interrupt pin event configuration
	typedef enum logic [1:0]
	{
		FIM_EV_LEVEL = 2'b00,
		FIM_EV_UNUSED = 2'b01,
		FIM_EV_REPEAT = 2'b10,
		FIM_EV_ONCE = 2'b11
	} fim_ev_mode_t;
	// interrupt pin sequencer states
	typedef enum logic [1:0]
	{
		FIM_ST_IDLE = 2'b00,
		FIM_ST_ON = 2'b01,
		FIM_ST_OFF = 2'b10
	} fim_irq_st_t;
	typedef struct packed
	{
		logic [7:0] chan_mask;
		logic [7:0] type_mask;
		logic [7:0] sys_latch;
		logic [7:0] sum_latch;
		logic [7:0] sys_live_prev;
		logic [7:0] sum_live_prev;
		logic [7:0] rdata;
		logic [7:0] us_cnt;
		logic [11:0] ms_cnt;
		logic pend_prev;
		fim_irq_st_t irq_st;
		logic irq_pin;
	} fim_state_t;
endpackage
